// *** design/bus_strobes.v ***
// external bus status strobes, byte selects and processor clocks
// assumes the core presents one cycle request, held until cycle_start
`timescale 1ns/100ps
`include "bus_strobe_map.vh"
module bus_strobes (
	input wire ref_clk,
	input wire rst,
	input wire wait_req,
	input wire [`KIND_W-1:0] core_kind,
	input wire core_boot,
	input wire core_byte,
	input wire core_lane_hi,
	input wire [`MEM_ADDR_W-1:0] core_mem_addr,
	input wire [`MEM_DATA_W-1:0] core_wdata,
	input wire [`EXT_ADDR_W-1:0] core_ext_addr,
	input wire cfg_boot_wr,
	input wire [`MEM_DATA_W-1:0] cfg_wdata,
	output wire core_take,
	output wire [`MEM_DATA_W-1:0] core_rdata,
	output wire pclk_out,
	output wire timing_clock_out,
	output wire fetch_active,
	output wire boot_space,
	output wire mem_read_write_n,
	output wire upper_byte_select,
	output wire lower_byte_select,
	output wire ext_bus_cycle_n,
	output wire ext_bus_read_write_n,
	output wire irq_acknowledge,
	output wire [`MEM_ADDR_W-1:0] mem_addr,
	input wire [`MEM_DATA_W-1:0] mem_data_in,
	output wire [`MEM_DATA_W-1:0] mem_data_out,
	output wire mem_data_oe_n,
	output wire [`EXT_ADDR_W-1:0] ext_addr,
	input wire [`EXT_DATA_W-1:0] ext_data_in,
	output wire [`EXT_DATA_W-1:0] ext_data_out,
	output wire ext_data_oe_n
);
	// ========================================
	// clocks
	wire cycle_start;
	clock_halver clock_halver_i (
		.ref_clk(ref_clk),
		.rst(rst),
		.wait_req(wait_req),
		.pclk_out(pclk_out),
		.timing_clock_out_out(timing_clock_out),
		.cycle_start(cycle_start)
	);
	assign core_take = cycle_start;
	// ========================================
	// decode of the requested cycle
	wire is_fetch = (core_kind == `KIND_FETCH);
	wire is_mem_wr = (core_kind == `KIND_MEM_WR);
	wire is_mem = is_fetch | (core_kind == `KIND_MEM_RD) | is_mem_wr;
	wire is_ext_rd = (core_kind == `KIND_EXT_RD);
	wire is_ext_wr = (core_kind == `KIND_EXT_WR);
	wire is_ack = (core_kind == `KIND_IRQ_ACK);
	wire is_ext = is_ext_rd | is_ext_wr;
	// ========================================
	// registered state, one current and one next value per item
	reg [`KIND_W-1:0] kind_q;
	reg [`KIND_W-1:0] kind_d;
	reg fetch_q;
	reg fetch_d;
	reg boot_q;
	reg boot_d;
	reg mem_rw_n_q;
	reg mem_rw_n_d;
	reg [1:0] lane_sel_q;
	reg [1:0] lane_sel_d;
	reg ext_cyc_n_q;
	reg ext_cyc_n_d;
	reg ext_rw_n_q;
	reg ext_rw_n_d;
	reg irq_ack_q;
	reg irq_ack_d;
	reg [`MEM_ADDR_W-1:0] mem_addr_q;
	reg [`MEM_ADDR_W-1:0] mem_addr_d;
	reg [`EXT_ADDR_W-1:0] ext_addr_q;
	reg [`EXT_ADDR_W-1:0] ext_addr_d;
	reg [`MEM_DATA_W-1:0] mem_wdata_q;
	reg [`MEM_DATA_W-1:0] mem_wdata_d;
	reg [`EXT_DATA_W-1:0] ext_wdata_q;
	reg [`EXT_DATA_W-1:0] ext_wdata_d;
	reg mem_oe_n_q;
	reg mem_oe_n_d;
	reg ext_oe_n_q;
	reg ext_oe_n_d;
	reg [`MEM_DATA_W-1:0] rdata_q;
	reg [`MEM_DATA_W-1:0] rdata_d;
	// ========================================
	// byte lanes: index 0 is bits 7..0, index 1 is bits 15..8
	wire [1:0] lane_hit;
	genvar lane;
	generate
		for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
			// a memory word takes both lanes, a memory byte only the lane it names; other cycles take none
			wire lane_named = (lane == 1) ? core_lane_hi : ~core_lane_hi;
			assign lane_hit[lane] = is_mem & (~core_byte | lane_named);
		end
	endgenerate
	// ========================================
	// next state: strobes other than boot_space move only at a cycle start
	always @* begin
		kind_d = kind_q;
		fetch_d = fetch_q;
		boot_d = boot_q;
		mem_rw_n_d = mem_rw_n_q;
		lane_sel_d = lane_sel_q;
		ext_cyc_n_d = ext_cyc_n_q;
		ext_rw_n_d = ext_rw_n_q;
		irq_ack_d = irq_ack_q;
		mem_addr_d = mem_addr_q;
		ext_addr_d = ext_addr_q;
		mem_wdata_d = mem_wdata_q;
		ext_wdata_d = ext_wdata_q;
		mem_oe_n_d = mem_oe_n_q;
		ext_oe_n_d = ext_oe_n_q;
		rdata_d = rdata_q;
		if (cycle_start) begin
			kind_d = core_kind;
			fetch_d = is_fetch;
			mem_rw_n_d = ~is_mem_wr;
			lane_sel_d = lane_hit;
			ext_cyc_n_d = ~is_ext;
			ext_rw_n_d = ~is_ext_wr;
			irq_ack_d = is_ack;
			// addresses hold through cycles that do not use their bus
			if (is_mem)
				mem_addr_d = core_mem_addr;
			if (is_ext)
				ext_addr_d = core_ext_addr;
			mem_wdata_d = core_wdata;
			ext_wdata_d = core_wdata;
			// data pins driven only during a write on that bus
			mem_oe_n_d = ~is_mem_wr;
			ext_oe_n_d = ~is_ext_wr;
			// read data of the cycle now ending, still on the pins
			if (kind_q == `KIND_EXT_RD)
				rdata_d = ext_data_in;
			else if (kind_q == `KIND_FETCH || kind_q == `KIND_MEM_RD)
				rdata_d = mem_data_in;
		end
		// a config write wins over a cycle that starts with it
		if (cfg_boot_wr)
			boot_d = cfg_wdata[`CFG_BOOT_BIT];
		else if (cycle_start && is_mem)
			boot_d = core_boot;
	end
	// ========================================
	// state registers
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			kind_q <= `KIND_IDLE;
			fetch_q <= `RST_FETCH;
			boot_q <= `RST_BOOT;
			mem_rw_n_q <= `RST_MEM_RW_N;
			lane_sel_q <= {`RST_UPPER_SEL, `RST_LOWER_SEL};
			ext_cyc_n_q <= `RST_EXT_CYC_N;
			ext_rw_n_q <= `RST_EXT_RW_N;
			irq_ack_q <= `RST_IRQ_ACK;
			mem_addr_q <= {`MEM_ADDR_W{1'b0}};
			ext_addr_q <= {`EXT_ADDR_W{1'b0}};
			mem_wdata_q <= {`MEM_DATA_W{1'b0}};
			ext_wdata_q <= {`EXT_DATA_W{1'b0}};
			mem_oe_n_q <= 1'b1;
			ext_oe_n_q <= 1'b1;
			rdata_q <= {`MEM_DATA_W{1'b0}};
		end else begin
			kind_q <= kind_d;
			fetch_q <= fetch_d;
			boot_q <= boot_d;
			mem_rw_n_q <= mem_rw_n_d;
			lane_sel_q <= lane_sel_d;
			ext_cyc_n_q <= ext_cyc_n_d;
			ext_rw_n_q <= ext_rw_n_d;
			irq_ack_q <= irq_ack_d;
			mem_addr_q <= mem_addr_d;
			ext_addr_q <= ext_addr_d;
			mem_wdata_q <= mem_wdata_d;
			ext_wdata_q <= ext_wdata_d;
			mem_oe_n_q <= mem_oe_n_d;
			ext_oe_n_q <= ext_oe_n_d;
			rdata_q <= rdata_d;
		end
	end
	// ========================================
	// outputs straight from the registers
	assign core_rdata = rdata_q;
	assign fetch_active = fetch_q;
	assign boot_space = boot_q;
	assign mem_read_write_n = mem_rw_n_q;
	assign upper_byte_select = lane_sel_q[1];
	assign lower_byte_select = lane_sel_q[0];
	assign ext_bus_cycle_n = ext_cyc_n_q;
	assign ext_bus_read_write_n = ext_rw_n_q;
	assign irq_acknowledge = irq_ack_q;
	assign mem_addr = mem_addr_q;
	assign mem_data_out = mem_wdata_q;
	assign mem_data_oe_n = mem_oe_n_q;
	assign ext_addr = ext_addr_q;
	assign ext_data_out = ext_wdata_q;
	assign ext_data_oe_n = ext_oe_n_q;
endmodule

// *** design/clock_halver.v ***
// divide-by-two processor and timing clock generator
// assumes ref_clk is the input clock and rst is asynchronous active high
`timescale 1ns/100ps
`include "bus_strobe_map.vh"
module clock_halver (
	input wire ref_clk,
	input wire rst,
	input wire wait_req,
	output wire pclk_out,
	output wire timing_clock_out_out,
	output wire cycle_start
);
	// ========================================
	// free phase and stretched phase
	reg timing_clock_out_q;
	reg pclk_q;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timing_clock_out_q <= `RST_TIMING_CLOCK_OUT;
			pclk_q <= `RST_PCLK;
		end else begin
			timing_clock_out_q <= ~timing_clock_out_q;
			if (pclk_q)
				pclk_q <= 1'b0;
			else if (!wait_req)
				pclk_q <= 1'b1;
		end
	end
	assign pclk_out = pclk_q;
	assign timing_clock_out_out = timing_clock_out_q;
	// rising edge of pclk coming next edge
	assign cycle_start = ~pclk_q & ~wait_req;
endmodule

// *** pkg/bus_strobe_map.vh ***
// constants for the external bus strobe and clock block
// assumes inclusion by the design files only
`ifndef BUS_STROBE_MAP_VH
`define BUS_STROBE_MAP_VH
// ========================================
// widths
`define MEM_ADDR_W 19
`define MEM_DATA_W 16
`define EXT_ADDR_W 3
`define EXT_DATA_W 16
// ========================================
// configuration word field
`define CFG_BOOT_BIT 3
// ========================================
// reset levels
`define RST_FETCH 1'b1
`define RST_BOOT 1'b1
`define RST_MEM_RW_N 1'b1
`define RST_UPPER_SEL 1'b1
`define RST_LOWER_SEL 1'b1
`define RST_EXT_CYC_N 1'b1
`define RST_EXT_RW_N 1'b1
`define RST_PCLK 1'b0
`define RST_TIMING_CLOCK_OUT 1'b0
`define RST_IRQ_ACK 1'b0
// ========================================
// cycle kinds
`define KIND_W 3
`define KIND_IDLE 3'h0
`define KIND_FETCH 3'h1
`define KIND_MEM_RD 3'h2
`define KIND_MEM_WR 3'h3
`define KIND_EXT_RD 3'h4
`define KIND_EXT_WR 3'h5
`define KIND_IRQ_ACK 3'h6
// ========================================
// timing
`define CLK_DIV 2
`define RESET_MIN_EDGES 4
`endif

// *** test/bus_partner.sv ***
// memory side model: data from address, waits on demand
// assumes slow comes from the bench
`timescale 1ns/100ps
module bus_partner (
	input wire ref_clk,
	input wire slow,
	input wire [18:0] mem_addr,
	input wire mem_read_write_n,
	input wire [2:0] ext_addr,
	input wire ext_bus_cycle_n,
	output wire [15:0] mem_data_in,
	output wire [15:0] ext_data_in,
	output logic wait_req
);
	// memory answers reads only; during a write the pins float high
	assign mem_data_in = mem_read_write_n ? (mem_addr[15:0] ^ 16'ha5a5) : 16'hffff;
	// an extension device answers only inside its own cycle
	assign ext_data_in = ext_bus_cycle_n ? 16'hffff : ({13'h0000, ext_addr} ^ 16'h5a5a);
	initial wait_req = 1'b0;
	always @(posedge ref_clk) wait_req <= slow & ~wait_req;
endmodule

// *** test/bus_strobes_chk.sv ***
// checker of bus_strobes outputs
// assumes the bind below
`timescale 1ns/100ps
module bus_strobes_chk (
	input wire ref_clk,
	input wire rst,
	input wire wait_req,
	input wire [2:0] core_kind,
	input wire core_take,
	input wire pclk_out,
	input wire timing_clock_out,
	input wire mem_read_write_n,
	input wire irq_acknowledge
);
	wire [3:0] tk = {core_take, core_kind};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_wr; tk == 4'hb |=> !mem_read_write_n; endproperty
	a_wr: assert property (p_wr) else $error("no write");
	property p_rd; tk == 4'ha |=> mem_read_write_n; endproperty
	a_rd: assert property (p_rd) else $error("no read");
	property p_ack; tk == 4'he |=> irq_acknowledge; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_idle; tk == 4'h8 |=> !irq_acknowledge; endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_go; core_take |=> pclk_out; endproperty
	a_go: assert property (p_go) else $error("no start");
	property p_wait; wait_req && !pclk_out |=> !pclk_out; endproperty
	a_wait: assert property (p_wait) else $error("wait ignored");
	property p_half; pclk_out |=> !pclk_out; endproperty
	a_half: assert property (p_half) else $error("pclk long");
	property p_timing_clock_out; 1 |=> timing_clock_out != $past(timing_clock_out); endproperty
	a_timing_clock_out: assert property (p_timing_clock_out) else $error("timing_clock_out stuck");
	c_wr: cover property (tk == 4'hb);
	c_ack: cover property (tk == 4'he);
	c_wait: cover property (wait_req && !pclk_out);
endmodule
bind bus_strobes bus_strobes_chk bus_strobes_chk_i (.*);

// *** test/test_bus_strobes.sv ***
// bench: cycle table, config, wait, reset
// assumes bus_partner on the memory side
`timescale 1ns/100ps
module test_bus_strobes;
	reg ref_clk = 0, rst = 1, core_boot = 0, core_byte = 0, core_lane_hi = 0, slow = 0;
	reg cfg_boot_wr = 0;
	reg [2:0] core_kind = 0;
	reg [18:0] core_mem_addr = 0;
	reg [15:0] cfg_wdata = 16'h0008;
	wire [15:0] core_wdata = ~core_mem_addr[15:0];
	wire [2:0] core_ext_addr = core_mem_addr[2:0];
	wire [2:0] ext_addr;
	wire [15:0] core_rdata, mem_data_in, mem_data_out, ext_data_out, ext_data_in;
	wire [18:0] mem_addr;
	wire core_take, pclk_out, timing_clock_out, fetch_active, boot_space, mem_read_write_n;
	wire upper_byte_select, lower_byte_select, ext_bus_cycle_n, ext_bus_read_write_n;
	wire irq_acknowledge, mem_data_oe_n, ext_data_oe_n, wait_req;
	wire [9:0] sv = {fetch_active, boot_space, mem_read_write_n, upper_byte_select,
		lower_byte_select, ext_bus_cycle_n, ext_bus_read_write_n, irq_acknowledge,
		pclk_out, timing_clock_out};
	reg [13:0] tab [0:7] = '{14'h0cfe, 14'h103e, 14'h1b16, 14'h122e,
		14'h2022, 14'h2820, 14'h3027, 14'h0026};
	integer mismatches = 0, total_checks = 0, i, n;
	bus_strobes bus_strobes_i (.*);
	bus_partner bus_partner_i (.*);
	always #5 ref_clk = ~ref_clk;
	task chk(input [18:0] seen, input [18:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task cyc(input integer j, input [7:0] e);
		{core_kind, core_boot, core_byte, core_lane_hi} = tab[j][13:8];
		for (n = 0; n < 20 && core_take !== 1'b1; n = n + 1) @(posedge ref_clk) #1;
		chk(core_take, 1'b1);
		@(posedge ref_clk) #1;
		chk(sv[9:2], e);
		chk(pclk_out, 1'b1);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		#1 chk(sv, 10'h3f8);
		rst = 0;
		$display("reset test done");
		for (i = 0; i < 8; i = i + 1) begin
			core_mem_addr = 19'h2a5c0 + i;
			slow = i > 5;
			cyc(i, tab[i][7:0]);
			chk({mem_data_oe_n, ext_data_oe_n}, {i != 2, i != 5});
			if (i == 0) chk(mem_addr, 19'h2a5c0);
			if (i == 2) chk(core_rdata, 16'h0064);
			if (i == 2) chk(mem_addr, 19'h2a5c2);
			if (i == 2) chk(mem_data_out, 16'h5a3d);
			if (i == 4) chk(ext_addr, 3'h4);
			if (i == 5) chk(ext_data_out, 16'h5a3a);
			if (i == 5) chk(core_rdata, 16'h5a5e);
			$display("row %0d", i);
		end
		cfg_boot_wr = 1;
		@(posedge ref_clk) #1 cfg_boot_wr = 0;
		chk(boot_space, 1'b1);
		cfg_wdata = 16'h0000;
		cfg_boot_wr = 1;
		@(posedge ref_clk) #1 cfg_boot_wr = 0;
		chk(boot_space, 1'b0);
		$display("config test done");
		rst = 1;
		#1 chk(sv, 10'h3f8);
		repeat (6) @(posedge ref_clk);
		#1 rst = 0;
		cyc(6, 8'h67);
		$display("config and reset done");
		test_done;
	end
	initial begin
		// about 2000 cycles, far past the span the tests need
		#20000;
		mismatches = mismatches + 1;
		test_done;
	end
endmodule
